/* File: pixel_comp_pkg.sv */
// Constants shared by the pixel compensation block.
package pixel_comp_pkg;
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_SETUP4 = 8'h04;
	localparam logic [7:0] ADDR_DEFAULTS = 8'h08;
	localparam logic [7:0] ADDR_CH0 = 8'h0c;
	localparam logic [7:0] ADDR_CH1 = 8'h10;
	localparam logic [7:0] ADDR_CH2 = 8'h14;
	localparam logic [7:0] ADDR_STATUS = 8'h18;
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_OFF_INT_BIT = 1;
	localparam int CTRL_GAIN_INT_BIT = 2;
	localparam int CTRL_MODE_LSB = 3;
	localparam int SETUP4_RSP_LSB = 0;
	localparam int SETUP4_WIDE_BIT = 4;
	localparam int SETUP4_INVERT_BIT = 5;
	localparam int DEF_GAIN_LSB = 0;
	localparam int DEF_OFF_LSB = 16;
	localparam int CH_OFFSET_LSB = 0;
	localparam int CH_GAIN_LSB = 16;
	localparam int STAT_PIXEL_LSB = 0;
	localparam int STAT_SAT_BIT = 16;
	localparam int STAT_PHASE_BIT = 17;
	localparam logic [2:0] MODE_G12_O4 = 3'h0;
	localparam logic [2:0] MODE_G11_O5 = 3'h1;
	localparam logic [2:0] MODE_G10_O6 = 3'h2;
	localparam logic [2:0] MODE_G11_DV_O4 = 3'h4;
	localparam logic [2:0] MODE_G10_DV_O5 = 3'h5;
	localparam logic [2:0] MODE_RESET = 3'h0;
	localparam logic [11:0] DEF_GAIN_RESET = 12'h800;
	localparam logic [5:0] DEF_OFF_RESET = 6'h00;
	localparam logic [15:0] COEF_WORD_RESET = 16'h8000;
	localparam logic [1:0] RSP_RESET = 2'h0;
	localparam logic [3:0] RESET_SAMPLE_BASE = 4'h4;
	localparam logic [3:0] SAMPLE_COUNT_MAX = 4'hf;
	localparam logic [11:0] PIXEL_MAX = 12'hfff;
	localparam int GAIN_UNITY_SHIFT = 11;
endpackage

/* File: comp_if.sv */
// Interface between the control logic and the compensation arithmetic.
`timescale 1ns/1ps
interface comp_if;
	logic [11:0] result;
	logic [15:0] word;
	logic [2:0] mode;
	logic off_int;
	logic gain_int;
	logic [5:0] def_off;
	logic [11:0] def_gain;
	logic [11:0] value;
	logic sat;
	logic dv;
	modport ctl(output result, word, mode, off_int, gain_int, def_off,
		def_gain, input value, sat, dv);
	modport math(input result, word, mode, off_int, gain_int, def_off,
		def_gain, output value, sat, dv);
endinterface

/* File: pixel_comp_math.sv */
// Offset, clamp, gain and clamp arithmetic for one pixel.
`timescale 1ns/1ps
module pixel_comp_math (
	comp_if.math c
);
	logic [11:0] gain12;
	logic [6:0] offs7;
	logic signed [13:0] sum;
	logic [11:0] clamped;
	logic [23:0] prod;
	logic sat_off;
	localparam int GAIN_SHIFT_TOP = pixel_comp_pkg::GAIN_UNITY_SHIFT + 12;

	always_comb begin
		gain12 = c.word[15:4];
		offs7 = {{3{c.word[3]}}, c.word[3:0]};
		c.dv = 1'b1;
		case (c.mode)
		pixel_comp_pkg::MODE_G11_O5: begin
			gain12 = {c.word[15:5], 1'b0};
			offs7 = {{2{c.word[4]}}, c.word[4:0]};
		end
		pixel_comp_pkg::MODE_G10_O6: begin
			gain12 = {c.word[15:6], 2'b00};
			offs7 = {c.word[5], c.word[5:0]};
		end
		pixel_comp_pkg::MODE_G11_DV_O4: begin
			gain12 = {c.word[15:5], 1'b0};
			c.dv = c.word[4];
		end
		pixel_comp_pkg::MODE_G10_DV_O5: begin
			gain12 = {c.word[15:6], 2'b00};
			offs7 = {{2{c.word[4]}}, c.word[4:0]};
			c.dv = c.word[5];
		end
		default: begin
			gain12 = c.word[15:4];
		end
		endcase
		if (c.off_int) begin
			offs7 = {c.def_off[5], c.def_off};
		end
		if (c.gain_int) begin
			gain12 = c.def_gain;
		end
		// Offset code counts in steps of four, two's complement.
		sum = $signed({2'b00, c.result}) +
			$signed({{5{offs7[6]}}, offs7, 2'b00});
		sat_off = 1'b1;
		if (sum < 0) begin
			clamped = 12'h000;
		end else if (sum > $signed({2'b00, pixel_comp_pkg::PIXEL_MAX})) begin
			clamped = pixel_comp_pkg::PIXEL_MAX;
		end else begin
			clamped = sum[11:0];
			sat_off = 1'b0;
		end
		// Half of full gain code is unity; the fraction is dropped.
		prod = 24'(clamped) * 24'(gain12);
		if (prod[23:GAIN_SHIFT_TOP] != 1'b0) begin
			c.value = pixel_comp_pkg::PIXEL_MAX;
			c.sat = 1'b1;
		end else begin
			c.value = prod[22:11];
			c.sat = sat_off;
		end
	end

endmodule

/* File: pixel_comp_top.sv */
// Register file, sample timing and output stage of the pixel back end.
`timescale 1ns/1ps
module pixel_comp_top (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic video_sample_pulse_i,
	input wire logic [11:0] converter_result_i,
	input wire logic converter_valid_i,
	input wire logic [7:0] coefficient_bus_i,
	input wire logic coefficient_strobe_i,
	output logic [11:0] pixel_output_bus_o,
	output logic pixel_valid_o,
	output logic saturation_flag_o,
	output logic reset_level_sample_o,
	output logic clamp_o,
	output logic [14:0] amp_gain_codes_o,
	output logic [26:0] offset_dac_codes_o
);
	logic comp_en_reg;
	logic off_int_reg;
	logic gain_int_reg;
	logic [2:0] mode_reg;
	logic [1:0] rsp_reg;
	logic wide_reg;
	logic invert_reg;
	logic [11:0] def_gain_reg;
	logic [5:0] def_off_reg;
	logic [4:0] gain_code_reg [3];
	logic [8:0] offset_code_reg [3];
	logic ack_reg;
	logic [31:0] dat_reg;
	logic [31:0] cur_word;
	logic [31:0] wr_word;
	logic [31:0] lane_mask;
	logic wr_go;
	logic [7:0] coef_hi_reg;
	logic coef_phase_reg;
	logic [15:0] coef_word_reg;
	logic [3:0] sample_cnt_reg;
	logic sample_reg;
	logic [11:0] pixel_reg;
	logic sat_reg;
	logic valid_reg;
	logic [11:0] stage_value;
	comp_if cif ();

	assign wb_dat_o = dat_reg;
	assign wb_ack_o = ack_reg;
	assign pixel_output_bus_o = pixel_reg;
	assign saturation_flag_o = sat_reg;
	assign pixel_valid_o = valid_reg;
	assign reset_level_sample_o = sample_reg;
	assign clamp_o = sample_reg;
	assign amp_gain_codes_o = {gain_code_reg[2], gain_code_reg[1],
		gain_code_reg[0]};
	assign offset_dac_codes_o = {offset_code_reg[2], offset_code_reg[1],
		offset_code_reg[0]};

	// Bus write request taken when not already answering.
	assign wr_go = wb_cyc_i && wb_stb_i && !ack_reg && wb_we_i;

	always_comb begin
		lane_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}},
			{8{wb_sel_i[0]}}};
		cur_word = 32'h0000_0000;
		case (wb_adr_i)
		pixel_comp_pkg::ADDR_CTRL: begin
			cur_word[pixel_comp_pkg::CTRL_EN_BIT] = comp_en_reg;
			cur_word[pixel_comp_pkg::CTRL_OFF_INT_BIT] = off_int_reg;
			cur_word[pixel_comp_pkg::CTRL_GAIN_INT_BIT] = gain_int_reg;
			cur_word[pixel_comp_pkg::CTRL_MODE_LSB +: 3] = mode_reg;
		end
		pixel_comp_pkg::ADDR_SETUP4: begin
			cur_word[pixel_comp_pkg::SETUP4_RSP_LSB +: 2] = rsp_reg;
			cur_word[pixel_comp_pkg::SETUP4_WIDE_BIT] = wide_reg;
			cur_word[pixel_comp_pkg::SETUP4_INVERT_BIT] = invert_reg;
		end
		pixel_comp_pkg::ADDR_DEFAULTS: begin
			cur_word[pixel_comp_pkg::DEF_GAIN_LSB +: 12] = def_gain_reg;
			cur_word[pixel_comp_pkg::DEF_OFF_LSB +: 6] = def_off_reg;
		end
		pixel_comp_pkg::ADDR_CH0: begin
			cur_word[pixel_comp_pkg::CH_OFFSET_LSB +: 9] = offset_code_reg[0];
			cur_word[pixel_comp_pkg::CH_GAIN_LSB +: 5] = gain_code_reg[0];
		end
		pixel_comp_pkg::ADDR_CH1: begin
			cur_word[pixel_comp_pkg::CH_OFFSET_LSB +: 9] = offset_code_reg[1];
			cur_word[pixel_comp_pkg::CH_GAIN_LSB +: 5] = gain_code_reg[1];
		end
		pixel_comp_pkg::ADDR_CH2: begin
			cur_word[pixel_comp_pkg::CH_OFFSET_LSB +: 9] = offset_code_reg[2];
			cur_word[pixel_comp_pkg::CH_GAIN_LSB +: 5] = gain_code_reg[2];
		end
		pixel_comp_pkg::ADDR_STATUS: begin
			cur_word[pixel_comp_pkg::STAT_PIXEL_LSB +: 12] = pixel_reg;
			cur_word[pixel_comp_pkg::STAT_SAT_BIT] = sat_reg;
			cur_word[pixel_comp_pkg::STAT_PHASE_BIT] = coef_phase_reg;
		end
		default: begin
			cur_word = 32'h0000_0000;
		end
		endcase
		wr_word = (cur_word & ~lane_mask) | (wb_dat_i & lane_mask);
	end

	// Wishbone answer, one cycle after the request is taken.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
			dat_reg <= 32'h0000_0000;
		end else begin
			ack_reg <= wb_cyc_i && wb_stb_i && !ack_reg;
			if (wb_cyc_i && wb_stb_i && !ack_reg && !wb_we_i) begin
				dat_reg <= cur_word;
			end
		end
	end

	// Control and setup bits.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			comp_en_reg <= 1'b0;
			off_int_reg <= 1'b0;
			gain_int_reg <= 1'b0;
			mode_reg <= pixel_comp_pkg::MODE_RESET;
			rsp_reg <= pixel_comp_pkg::RSP_RESET;
			wide_reg <= 1'b0;
			invert_reg <= 1'b0;
			def_gain_reg <= pixel_comp_pkg::DEF_GAIN_RESET;
			def_off_reg <= pixel_comp_pkg::DEF_OFF_RESET;
		end else if (wr_go) begin
			if (wb_adr_i == pixel_comp_pkg::ADDR_CTRL) begin
				comp_en_reg <= wr_word[pixel_comp_pkg::CTRL_EN_BIT];
				off_int_reg <= wr_word[pixel_comp_pkg::CTRL_OFF_INT_BIT];
				gain_int_reg <= wr_word[pixel_comp_pkg::CTRL_GAIN_INT_BIT];
				mode_reg <= wr_word[pixel_comp_pkg::CTRL_MODE_LSB +: 3];
			end
			if (wb_adr_i == pixel_comp_pkg::ADDR_SETUP4) begin
				rsp_reg <= wr_word[pixel_comp_pkg::SETUP4_RSP_LSB +: 2];
				wide_reg <= wr_word[pixel_comp_pkg::SETUP4_WIDE_BIT];
				invert_reg <= wr_word[pixel_comp_pkg::SETUP4_INVERT_BIT];
			end
			if (wb_adr_i == pixel_comp_pkg::ADDR_DEFAULTS) begin
				def_gain_reg <= wr_word[pixel_comp_pkg::DEF_GAIN_LSB +: 12];
				def_off_reg <= wr_word[pixel_comp_pkg::DEF_OFF_LSB +: 6];
			end
		end
	end

	// Per channel amplifier gain and offset codes.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int i = 0; i < 3; i++) begin
				gain_code_reg[i] <= 5'h00;
				offset_code_reg[i] <= 9'h000;
			end
		end else if (wr_go) begin
			for (int i = 0; i < 3; i++) begin
				if (wb_adr_i == 8'(pixel_comp_pkg::ADDR_CH0 + 8'(4 * i))) begin
					gain_code_reg[i] <=
						wr_word[pixel_comp_pkg::CH_GAIN_LSB +: 5];
					offset_code_reg[i] <=
						wr_word[pixel_comp_pkg::CH_OFFSET_LSB +: 9];
				end
			end
		end
	end

	// Coefficient bytes: first byte is the high half of the word.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			coef_hi_reg <= 8'h00;
			coef_phase_reg <= 1'b0;
			coef_word_reg <= pixel_comp_pkg::COEF_WORD_RESET;
		end else if (coefficient_strobe_i) begin
			if (!coef_phase_reg) begin
				coef_hi_reg <= coefficient_bus_i;
				coef_phase_reg <= 1'b1;
			end else begin
				coef_word_reg <= {coef_hi_reg, coefficient_bus_i};
				coef_phase_reg <= 1'b0;
			end
		end
	end

	// Reset sample and clamp timing counted from the sample pulse.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sample_cnt_reg <= 4'h0;
			sample_reg <= 1'b0;
		end else begin
			if (video_sample_pulse_i) begin
				sample_cnt_reg <= 4'h1;
			end else if (sample_cnt_reg != 4'h0 &&
				sample_cnt_reg != pixel_comp_pkg::SAMPLE_COUNT_MAX) begin
				sample_cnt_reg <= sample_cnt_reg + 4'h1;
			end
			sample_reg <= (sample_cnt_reg == 4'(pixel_comp_pkg::RESET_SAMPLE_BASE
				+ {2'b00, rsp_reg}));
		end
	end

	assign cif.result = converter_result_i;
	assign cif.word = coef_word_reg;
	assign cif.mode = mode_reg;
	assign cif.off_int = off_int_reg;
	assign cif.gain_int = gain_int_reg;
	assign cif.def_off = def_off_reg;
	assign cif.def_gain = def_gain_reg;

	pixel_comp_math u_math (
		.c(cif.math)
	);

	always_comb begin
		stage_value = comp_en_reg ? cif.value : converter_result_i;
		if (invert_reg) begin
			stage_value = ~stage_value;
		end
	end

	// Output stage: pixel, flag and valid leave together.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pixel_reg <= 12'h000;
			sat_reg <= 1'b0;
			valid_reg <= 1'b0;
		end else begin
			valid_reg <= converter_valid_i &&
				(!comp_en_reg || !mode_reg[2] || cif.dv);
			if (converter_valid_i) begin
				pixel_reg <= wide_reg ? stage_value :
					{2'b00, stage_value[11:2]};
				sat_reg <= comp_en_reg && cif.sat;
			end
		end
	end

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	property p_wide_pass;
		converter_valid_i && !comp_en_reg && !invert_reg && wide_reg
		|=> pixel_output_bus_o == $past(converter_result_i);
	endproperty
	a_wide_pass: assert property (p_wide_pass)
		else $error("Wide pass through output differs from result.");

	property p_narrow;
		converter_valid_i && !wide_reg && !comp_en_reg && !invert_reg
		|=> pixel_output_bus_o == {2'b00, $past(converter_result_i[11:2])};
	endproperty
	a_narrow: assert property (p_narrow)
		else $error("Narrow output is not the top ten bits.");

	sequence s_pulse_then_quiet;
		video_sample_pulse_i && rsp_reg == 2'h0
		##1 (!video_sample_pulse_i && rsp_reg == 2'h0) [*4];
	endsequence
	property p_reset_sample;
		s_pulse_then_quiet |=> reset_level_sample_o && clamp_o;
	endproperty
	a_reset_sample: assert property (p_reset_sample)
		else $error("Reset sample missing on fourth edge.");

	property p_no_early_sample;
		video_sample_pulse_i |=> !reset_level_sample_o ##1
			!reset_level_sample_o;
	endproperty
	a_no_early_sample: assert property (p_no_early_sample)
		else $error("Reset sample came too early.");

	property p_gain_write;
		wr_go && wb_adr_i == pixel_comp_pkg::ADDR_CH1 && wb_sel_i[2]
		|=> amp_gain_codes_o[9:5] == $past(wb_dat_i[20:16]);
	endproperty
	a_gain_write: assert property (p_gain_write)
		else $error("Channel gain code not stored.");

	property p_invert;
		converter_valid_i && !comp_en_reg && invert_reg && wide_reg
		|=> pixel_output_bus_o == ~$past(converter_result_i);
	endproperty
	a_invert: assert property (p_invert)
		else $error("Inverted output is not the complement.");

	property p_coef_join;
		coefficient_strobe_i && coef_phase_reg
		|=> coef_word_reg == {$past(coef_hi_reg), $past(coefficient_bus_i)};
	endproperty
	a_coef_join: assert property (p_coef_join)
		else $error("Coefficient word not joined high byte first.");

	property p_unity_defaults;
		converter_valid_i && comp_en_reg && off_int_reg && gain_int_reg &&
		def_off_reg == 6'h00 && def_gain_reg == 12'h800 && wide_reg &&
		!invert_reg
		|=> pixel_output_bus_o == $past(converter_result_i) &&
			!saturation_flag_o;
	endproperty
	a_unity_defaults: assert property (p_unity_defaults)
		else $error("Unity gain and zero offset altered the pixel.");

	property p_flag_with_pixel;
		$changed(saturation_flag_o) |-> $past(converter_valid_i);
	endproperty
	a_flag_with_pixel: assert property (p_flag_with_pixel)
		else $error("Saturation flag moved without a pixel.");

	property p_bypass_no_flag;
		converter_valid_i && !comp_en_reg |=> !saturation_flag_o;
	endproperty
	a_bypass_no_flag: assert property (p_bypass_no_flag)
		else $error("Flag raised while compensation is off.");
endmodule

/* File: coef_source.sv */
// Behavioural model of the external coefficient memory.
`timescale 1ns/1ps
module coef_source (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic send_i,
	input wire logic [15:0] word_i,
	input wire logic slow_i,
	output logic [7:0] byte_o,
	output logic strobe_o,
	output logic busy_o
);
	logic [1:0] step_reg;
	logic [15:0] word_reg;
	// Two bytes per pixel, high byte first, with an optional stall.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			step_reg <= 2'h0;
			strobe_o <= 1'b0;
			busy_o <= 1'b0;
			byte_o <= 8'h5a;
			word_reg <= 16'h0000;
		end else begin
			strobe_o <= 1'b0;
			byte_o <= ~byte_o;
			case (step_reg)
				2'h0: if (send_i) begin
					word_reg <= word_i;
					byte_o <= word_i[15:8];
					strobe_o <= 1'b1;
					busy_o <= 1'b1;
					step_reg <= slow_i ? 2'h2 : 2'h1;
				end
				2'h1: begin
					byte_o <= word_reg[7:0];
					strobe_o <= 1'b1;
					step_reg <= 2'h3;
				end
				2'h2: step_reg <= 2'h1;
				default: begin
					busy_o <= 1'b0;
					step_reg <= 2'h0;
				end
			endcase
		end
	end
endmodule

/* File: tb_pixel_offset_gain_compensation.sv */
// Self-checking testbench of the pixel compensation back end.
`timescale 1ns/1ps
module tb_pixel_offset_gain_compensation;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'hf;
	logic [31:0] wdat = 32'h0, rdat;
	logic ack, vsp = 1'b0, cvld = 1'b0, send = 1'b0, slow = 1'b0;
	logic [11:0] cres = 12'h000, pout;
	logic [7:0] cbyte;
	logic cstb, busy, pvld, sat, rsmp, clamp;
	logic [15:0] sword = 16'h0;
	logic [14:0] amp;
	logic [26:0] offs;
	int err_total = 0;
	int num_checks = 0;
	always #25 clk = ~clk;
	pixel_comp_top dut (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.video_sample_pulse_i(vsp), .converter_result_i(cres),
		.converter_valid_i(cvld), .coefficient_bus_i(cbyte),
		.coefficient_strobe_i(cstb), .pixel_output_bus_o(pout),
		.pixel_valid_o(pvld), .saturation_flag_o(sat),
		.reset_level_sample_o(rsmp), .clamp_o(clamp),
		.amp_gain_codes_o(amp), .offset_dac_codes_o(offs));
	coef_source src (.clk_i(clk), .rst_i(rst), .send_i(send),
		.word_i(sword), .slow_i(slow), .byte_o(cbyte), .strobe_o(cstb),
		.busy_o(busy));
	task automatic summarize();
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		if (n >= 20) begin
			err_total++;
			summarize();
		end
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk(q, e);
	endtask
	task automatic pix(input logic [11:0] r, input logic [11:0] e,
		input logic f, input logic v);
		cvld <= 1'b1;
		cres <= r;
		@(posedge clk);
		cvld <= 1'b0;
		#1;
		chk({20'h0, pout}, {20'h0, e});
		chk({31'h0, sat}, {31'h0, f});
		chk({31'h0, pvld}, {31'h0, v});
		@(posedge clk);
	endtask
	task automatic put(input logic [15:0] w, input logic s);
		int n;
		n = 0;
		send <= 1'b1;
		sword <= w;
		slow <= s;
		@(posedge clk);
		send <= 1'b0;
		do begin
			@(posedge clk);
			n++;
		end while (busy !== 1'b0 && n < 10);
		if (n >= 10) begin
			err_total++;
			summarize();
		end
	endtask
	task automatic ex(input logic [11:0] r, input logic [3:0] o,
		input logic [11:0] g, input logic [11:0] e, input logic f,
		input logic s);
		vsp <= 1'b1;
		@(posedge clk);
		vsp <= 1'b0;
		repeat (14) @(posedge clk);
		put({g, o}, s);
		pix(r, e, f, 1'b1);
	endtask
	task automatic sample_pos(input logic [1:0] p);
		int n;
		n = 0;
		wr(8'h04, {28'h0000001, 2'b00, p});
		vsp <= 1'b1;
		@(posedge clk);
		vsp <= 1'b0;
		do begin
			@(posedge clk);
			n++;
			#1;
		end while (rsmp !== 1'b1 && n < 12);
		chk(32'(n), 32'(4 + p));
		chk({31'h0, clamp}, 32'h1);
		@(posedge clk);
		#1;
		chk({31'h0, rsmp}, 32'h0);
		@(posedge clk);
	endtask
	task automatic codes();
		wr(8'h0c, 32'h001f01a4);
		wr(8'h10, 32'h000a00ff);
		wr(8'h14, 32'h00110100);
		chk({17'h0, amp}, {17'h0, 5'h11, 5'h0a, 5'h1f});
		chk({5'h0, offs}, {5'h0, 9'h100, 9'h0ff, 9'h1a4});
		rd(8'h0c, 32'h001f01a4);
		sel <= 4'h4;
		wr(8'h10, 32'h001501ff);
		sel <= 4'hf;
		rd(8'h10, 32'h001500ff);
	endtask
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rd(8'h00, 32'h0);
		rd(8'h08, 32'h00000800);
		rd(8'h40, 32'h0);
		pix(12'habc, 12'h2af, 1'b0, 1'b1);
		wr(8'h04, 32'h10);
		pix(12'hfff, 12'hfff, 1'b0, 1'b1);
		pix(12'h000, 12'h000, 1'b0, 1'b1);
		wr(8'h04, 32'h30);
		pix(12'h123, 12'hedc, 1'b0, 1'b1);
		for (int p = 0; p < 4; p++) begin
			sample_pos(p[1:0]);
		end
		codes();
		wr(8'h00, 32'h01);
		ex(12'd2048, 4'h0, 12'd2048, 12'd2048, 1'b0, 1'b0);
		ex(12'd2048, 4'h8, 12'd2048, 12'd2016, 1'b0, 1'b1);
		ex(12'd2048, 4'h2, 12'd2048, 12'd2056, 1'b0, 1'b0);
		ex(12'd4091, 4'h2, 12'd2048, 12'd4095, 1'b1, 1'b0);
		ex(12'd4091, 4'h2, 12'd512, 12'd1023, 1'b1, 1'b1);
		ex(12'd2048, 4'h0, 12'd2560, 12'd2560, 1'b0, 1'b0);
		ex(12'd2048, 4'h0, 12'd512, 12'd512, 1'b0, 1'b0);
		ex(12'd2049, 4'h0, 12'd4095, 12'd4095, 1'b1, 1'b0);
		ex(12'd2048, 4'h0, 12'd4095, 12'd4095, 1'b0, 1'b1);
		wr(8'h00, 32'h09);
		put({11'd1024, 5'h10}, 1'b0);
		pix(12'd2048, 12'd1984, 1'b0, 1'b1);
		wr(8'h00, 32'h11);
		put({10'd512, 6'h20}, 1'b1);
		pix(12'd2048, 12'd1920, 1'b0, 1'b1);
		wr(8'h00, 32'h21);
		put({11'd1024, 1'b0, 4'h7}, 1'b0);
		pix(12'd2048, 12'd2076, 1'b0, 1'b0);
		wr(8'h00, 32'h29);
		put({10'd512, 1'b1, 5'h0f}, 1'b0);
		pix(12'd2048, 12'd2108, 1'b0, 1'b1);
		wr(8'h08, 32'h003e0400);
		wr(8'h00, 32'h07);
		pix(12'd2048, 12'd1020, 1'b0, 1'b1);
		wr(8'h08, 32'h00000800);
		pix(12'h123, 12'h123, 1'b0, 1'b1);
		rd(8'h18, 32'h00000123);
		summarize();
	end
endmodule
